// >>> inc/opv_pkg.sv
// Shared constants and types of the one-time-programmable memory programmer.
package opv_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PULSE_US      = 100;
    localparam int PULSE_MIN_US  = 95;
    localparam int PULSE_MAX_US  = 105;
    localparam int SETUP_US      = 2;
    localparam int DV_US         = 1;
    localparam int SYNC_LAT      = 4;
    localparam int MAX_RETRY     = 10;
    localparam int ADDR_W        = 16;
    localparam int DATA_W        = 8;
    localparam int FIFO_DEPTH    = 8;
    localparam int PULSE_CYC     = (PULSE_US * 1000) / CLK_PERIOD_NS;
    localparam int SETUP_CYC     = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DV_CYC        = (DV_US * 1000) / CLK_PERIOD_NS;
    localparam int READ_CYC      = DV_CYC + SYNC_LAT;
    localparam logic [15:0] TIMER_RST = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE, ST_RAMP, ST_VREST, ST_FETCH, ST_SETUP,
        ST_PULSE, ST_HOLD, ST_VREL, ST_READ, ST_CHECK
    } opv_state_t;

    typedef enum logic [1:0] {PH_P1, PH_LOOP, PH_FINAL, PH_ID} opv_phase_t;
endpackage : opv_pkg

// >>> inc/opv_strm_if.sv
// Valid/ready byte stream between the programmer's own modules.
`timescale 1ns/1ps
interface opv_strm_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : opv_strm_if

// >>> src/opv_fifo.sv
// Small source-image FIFO with registered storage and a registered ready flag.
`timescale 1ns/1ps
module opv_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input wire logic    clk,
    input wire logic    rst_b,
    input wire logic    clk_en,
    opv_strm_if.snk     wr,
    opv_strm_if.src     rd
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [W-1:0]  mem_d [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic          ready_q, ready_d;
    logic          push, pop;

    // Ready is a flop so that back-pressure reaches the source without a comb path.
    assign wr.ready = ready_q;
    assign rd.valid = (cnt_q != '0);
    assign rd.data  = mem_q[rp_q];

    // Next pointers, count and storage.
    always_comb begin
        push    = wr.valid && ready_q;
        pop     = rd.ready && (cnt_q != '0);
        mem_d   = mem_q;
        if (push) begin
            mem_d[wp_q] = wr.data;
        end
        wp_d    = wp_q + PW'(push);
        rp_d    = rp_q + PW'(pop);
        cnt_d   = cnt_q + CW'(push) - CW'(pop);
        ready_d = (cnt_d != FULL);
    end

    // State registers, frozen while the clock enable is low.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wp_q    <= '0;
            rp_q    <= '0;
            cnt_q   <= '0;
            ready_q <= 1'b0;
        end else if (clk_en) begin
            mem_q   <= mem_d;
            wp_q    <= wp_d;
            rp_q    <= rp_d;
            cnt_q   <= cnt_d;
            ready_q <= ready_d;
        end
    end
endmodule : opv_fifo

// >>> src/opv_prog.sv
// Programmer that burns, verifies and identifies an external 64K x 8 OTP memory.
`timescale 1ns/1ps
module opv_prog
    import opv_pkg::*;
#(
    parameter int ADW                 = ADDR_W,
    parameter int PROGRAM_PULSE_WIDTH = PULSE_CYC,
    parameter int SETUP_CYCLES        = SETUP_CYC,
    parameter int READ_CYCLES         = READ_CYC
) (
    input  wire logic              CLOCK,
    input  wire logic              RST_B,
    input  wire logic              CLK_EN,
    input  wire logic              START,
    input  wire logic              ID_REQ,
    input  wire logic [DATA_W-1:0] SRC_DATA,
    input  wire logic              SRC_VALID,
    output wire logic              SRC_READY,
    output logic [ADW-1:0]         PIN_ADDR,
    output logic [DATA_W-1:0]      PIN_DATA_DRV,
    output logic                   PIN_DATA_OE,
    input  wire logic [DATA_W-1:0] DATA_OUT_LINES,
    output logic                   PIN_CE_B,
    output logic                   PIN_OE_B,
    output logic                   PIN_VPP_EN,
    output logic                   PIN_VCC_PROG,
    output logic                   ID_HIGH_VOLTAGE_LINE,
    output logic                   BUSY,
    output logic                   DONE,
    output logic                   PASS,
    output logic                   FAIL,
    output logic [DATA_W-1:0]      ID_MFR,
    output logic [DATA_W-1:0]      ID_DEV
);
    localparam logic [15:0]    PULSE_T = 16'(PROGRAM_PULSE_WIDTH - 1);
    localparam logic [15:0]    SETUP_T = 16'(SETUP_CYCLES - 1);
    localparam logic [15:0]    READ_T  = 16'(READ_CYCLES - 1);
    localparam logic [3:0]     RETRY_MAX = 4'(MAX_RETRY);
    localparam logic [ADW-1:0] ADDR_ONE  = {{(ADW-1){1'b0}}, 1'b1};

    opv_strm_if #(.W(DATA_W)) src_if ();
    opv_strm_if #(.W(DATA_W)) img_if ();

    opv_state_t        state_q, state_d;
    opv_phase_t        phase_q, phase_d;
    logic [ADW-1:0]    addr_q, addr_d;
    logic [DATA_W-1:0] data_q, data_d, dout_q, dout_d, rd_q, rd_d;
    logic [DATA_W-1:0] mfr_q, mfr_d, dev_q, dev_d;
    logic [15:0]       timer_q, timer_d;
    logic [3:0]        retry_q, retry_d;
    logic              doe_q, doe_d, ce_b_q, ce_b_d, oe_b_q, oe_b_d;
    logic              vpp_q, vpp_d, vcc_q, vcc_d, idhv_q, idhv_d, pend_q, pend_d;
    logic              busy_q, busy_d, done_q, done_d, pass_q, pass_d, fail_q, fail_d;
    logic [DATA_W-1:0] s1_q, s2_q, s3_q, stb_q, stb_d;
    logic              tdone, last, match;
    logic [15:0]       pw_cnt_q;

    // Source bytes pass the FIFO; the sequencer pops one only while fetching.
    assign src_if.valid = SRC_VALID;
    assign src_if.data  = SRC_DATA;
    assign SRC_READY    = src_if.ready;
    assign img_if.ready = (state_q == ST_FETCH);

    opv_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk    (CLOCK),
        .rst_b  (RST_B),
        .clk_en (CLK_EN),
        .wr     (src_if),
        .rd     (img_if)
    );

    // A data bit is accepted only once the second and third stages agree.
    for (genvar i = 0; i < DATA_W; i++) begin : g_sync
        assign stb_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stb_q[i];
    end

    assign tdone = (timer_q == TIMER_RST);
    assign last  = (addr_q == {ADW{1'b1}});
    assign match = (rd_q == data_q);

    // Sequencer next state; every timed wait loads its count minus one.
    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        addr_d  = addr_q;
        data_d  = data_q;
        dout_d  = dout_q;
        rd_d    = rd_q;
        mfr_d   = mfr_q;
        dev_d   = dev_q;
        retry_d = retry_q;
        doe_d   = doe_q;
        ce_b_d  = ce_b_q;
        oe_b_d  = oe_b_q;
        vpp_d   = vpp_q;
        vcc_d   = vcc_q;
        idhv_d  = idhv_q;
        pend_d  = pend_q;
        busy_d  = busy_q;
        pass_d  = pass_q;
        fail_d  = fail_q;
        done_d  = 1'b0;
        timer_d = tdone ? timer_q : timer_q - 16'h0001;
        case (state_q)
            ST_IDLE: begin
                if (START) begin
                    phase_d = PH_P1;
                    addr_d  = '0;
                    vcc_d   = 1'b1;
                    busy_d  = 1'b1;
                    pass_d  = 1'b0;
                    fail_d  = 1'b0;
                    pend_d  = 1'b0;
                    timer_d = SETUP_T;
                    state_d = ST_RAMP;
                end else if (ID_REQ) begin
                    phase_d = PH_ID;
                    addr_d  = '0;
                    idhv_d  = 1'b1;
                    busy_d  = 1'b1;
                    doe_d   = 1'b0;
                    oe_b_d  = 1'b0;
                    timer_d = SETUP_T;
                    state_d = ST_VREL;
                end
            end
            ST_RAMP: begin
                if (tdone) begin
                    vpp_d   = 1'b1;
                    timer_d = SETUP_T;
                    state_d = ST_VREST;
                end
            end
            ST_VREST: begin
                if (tdone) begin
                    pend_d  = 1'b0;
                    doe_d   = pend_q;
                    timer_d = SETUP_T;
                    state_d = pend_q ? ST_SETUP : ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (img_if.valid) begin
                    data_d = img_if.data;
                    if (phase_q == PH_P1) begin
                        dout_d  = img_if.data;
                        doe_d   = 1'b1;
                        timer_d = SETUP_T;
                        state_d = ST_SETUP;
                    end else if (phase_q == PH_LOOP) begin
                        retry_d = 4'h0;
                        dout_d  = img_if.data;
                        doe_d   = 1'b0;
                        vpp_d   = 1'b0;
                        oe_b_d  = 1'b0;
                        timer_d = SETUP_T;
                        state_d = ST_VREL;
                    end else begin
                        ce_b_d  = 1'b0;
                        oe_b_d  = 1'b0;
                        timer_d = READ_T;
                        state_d = ST_READ;
                    end
                end
            end
            ST_SETUP: begin
                if (tdone) begin
                    ce_b_d  = 1'b0;
                    timer_d = PULSE_T;
                    state_d = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (tdone) begin
                    ce_b_d  = 1'b1;
                    timer_d = SETUP_T;
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (tdone) begin
                    if (phase_q == PH_P1) begin
                        doe_d   = 1'b0;
                        addr_d  = last ? '0 : addr_q + ADDR_ONE;
                        phase_d = last ? PH_LOOP : PH_P1;
                        state_d = ST_FETCH;
                    end else begin
                        doe_d   = 1'b0;
                        vpp_d   = 1'b0;
                        oe_b_d  = 1'b0;
                        timer_d = SETUP_T;
                        state_d = ST_VREL;
                    end
                end
            end
            ST_VREL: begin
                if (tdone) begin
                    ce_b_d  = 1'b0;
                    timer_d = READ_T;
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                if (tdone) begin
                    rd_d    = stb_q;
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                ce_b_d  = 1'b1;
                oe_b_d  = 1'b1;
                timer_d = SETUP_T;
                state_d = ST_VREST;
                case (phase_q)
                    PH_LOOP: begin
                        if (match && last) begin
                            phase_d = PH_FINAL;
                            addr_d  = '0;
                            vcc_d   = 1'b0;
                        end else if (match) begin
                            addr_d  = addr_q + ADDR_ONE;
                            vpp_d   = 1'b1;
                        end else if (retry_q == RETRY_MAX) begin
                            fail_d  = 1'b1;
                            vcc_d   = 1'b0;
                            busy_d  = 1'b0;
                            done_d  = 1'b1;
                            state_d = ST_IDLE;
                        end else begin
                            retry_d = retry_q + 4'h1;
                            vpp_d   = 1'b1;
                            pend_d  = 1'b1;
                        end
                    end
                    PH_FINAL: begin
                        fail_d  = fail_q || !match;
                        addr_d  = addr_q + ADDR_ONE;
                        state_d = ST_FETCH;
                        if (last) begin
                            pass_d  = match && !fail_q;
                            busy_d  = 1'b0;
                            done_d  = 1'b1;
                            state_d = ST_IDLE;
                        end
                    end
                    PH_ID: begin
                        if (!addr_q[0]) begin
                            mfr_d   = rd_q;
                            addr_d  = ADDR_ONE;
                            ce_b_d  = 1'b0;
                            oe_b_d  = 1'b0;
                            timer_d = READ_T;
                            state_d = ST_READ;
                        end else begin
                            dev_d   = rd_q;
                            idhv_d  = 1'b0;
                            addr_d  = '0;
                            busy_d  = 1'b0;
                            done_d  = 1'b1;
                            state_d = ST_IDLE;
                        end
                    end
                    default: state_d = ST_IDLE;
                endcase
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Registers only; pins are idle and supplies at read level after reset.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= ST_IDLE;
            phase_q <= PH_P1;
            addr_q  <= '0;
            data_q  <= '0;
            dout_q  <= '0;
            rd_q    <= '0;
            mfr_q   <= '0;
            dev_q   <= '0;
            timer_q <= TIMER_RST;
            retry_q <= 4'h0;
            doe_q   <= 1'b0;
            ce_b_q  <= 1'b1;
            oe_b_q  <= 1'b1;
            vpp_q   <= 1'b0;
            vcc_q   <= 1'b0;
            idhv_q  <= 1'b0;
            pend_q  <= 1'b0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            pass_q  <= 1'b0;
            fail_q  <= 1'b0;
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            stb_q   <= '0;
        end else if (CLK_EN) begin
            state_q <= state_d;
            phase_q <= phase_d;
            addr_q  <= addr_d;
            data_q  <= data_d;
            dout_q  <= dout_d;
            rd_q    <= rd_d;
            mfr_q   <= mfr_d;
            dev_q   <= dev_d;
            timer_q <= timer_d;
            retry_q <= retry_d;
            doe_q   <= doe_d;
            ce_b_q  <= ce_b_d;
            oe_b_q  <= oe_b_d;
            vpp_q   <= vpp_d;
            vcc_q   <= vcc_d;
            idhv_q  <= idhv_d;
            pend_q  <= pend_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
            pass_q  <= pass_d;
            fail_q  <= fail_d;
            s1_q    <= DATA_OUT_LINES;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            stb_q   <= stb_d;
        end
    end

    assign PIN_ADDR             = addr_q;
    assign PIN_DATA_DRV         = dout_q;
    assign PIN_DATA_OE          = doe_q;
    assign PIN_CE_B             = ce_b_q;
    assign PIN_OE_B             = oe_b_q;
    assign PIN_VPP_EN           = vpp_q;
    assign PIN_VCC_PROG         = vcc_q;
    assign ID_HIGH_VOLTAGE_LINE = idhv_q;
    assign BUSY                 = busy_q;
    assign DONE                 = done_q;
    assign PASS                 = pass_q;
    assign FAIL                 = fail_q;
    assign ID_MFR               = mfr_q;
    assign ID_DEV               = dev_q;

    // Counts cycles of chip select low, read only by the checks below.
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            pw_cnt_q <= 16'h0000;
        end else if (CLK_EN) begin
            pw_cnt_q <= ce_b_q ? 16'h0000 : pw_cnt_q + 16'h0001;
        end
    end

    sequence s_verify_fail;
        state_q == ST_CHECK && phase_q == PH_LOOP && !match && retry_q == RETRY_MAX;
    endsequence
    sequence s_stopped;
        state_q == ST_IDLE && fail_q && done_q;
    endsequence

    pulse_width_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $rose(ce_b_q) && $past(vpp_q) |-> pw_cnt_q == 16'(PROGRAM_PULSE_WIDTH))
        else $error("Program pulse width wrong.");
    start_addr_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $rose(vcc_q) |-> addr_q == '0) else $error("Session did not start at zero.");
    volt_order_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $fell(ce_b_q) && doe_q |-> vpp_q && vcc_q) else $error("Pulse without voltages.");
    pass_one_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        phase_q == PH_P1 |-> state_q != ST_READ) else $error("Verify during first pass.");
    loop_start_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        $past(phase_q) == PH_P1 && $past(busy_q) && phase_q != PH_P1 |-> phase_q == PH_LOOP
        && addr_q == '0) else $error("Loop did not restart at zero.");
    retry_bound_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        state_q == ST_HOLD && phase_q == PH_LOOP && tdone |=> state_q == ST_VREL
        && retry_q <= RETRY_MAX) else $error("Reprogram pulse not verified.");
    fail_stop_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        s_verify_fail and CLK_EN |=> s_stopped) else $error("Failed part not stopped.");
    next_addr_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        state_q == ST_CHECK && phase_q == PH_LOOP && match && !last && CLK_EN
        |=> addr_q == $past(addr_q) + ADDR_ONE) else $error("Address did not advance.");
    final_volt_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        phase_q == PH_FINAL && state_q == ST_READ |-> !vpp_q && !vcc_q && !oe_b_q)
        else $error("Final read at program voltages.");
    id_mode_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        phase_q == PH_ID && state_q == ST_READ |-> idhv_q && addr_q[ADW-1:1] == '0)
        else $error("Identification levels wrong.");
    data_release_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
        state_q == ST_READ |-> !doe_q && !vpp_q) else $error("Data driven during read.");
endmodule : opv_prog

// >>> tb/opv_mem_model.sv
// Behavioural model of the one-time-programmable memory on the far side of the programmer.
`timescale 1ns/1ps
module opv_mem_model #(
    parameter int         AW       = 4,
    parameter int         PW       = 8,
    parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value.
    parameter logic [7:0] DEV_ID   = 8'hC3  // Arbitrary value.
) (
    input  wire logic          clk,
    input  wire logic          new_part,
    input  wire logic [3:0]    need,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    din,
    input  wire logic          din_oe,
    input  wire logic          ce_b,
    input  wire logic          oe_b,
    input  wire logic          vpp_en,
    input  wire logic          vcc_prog,
    input  wire logic          id_hv,
    output logic [7:0]         dout,
    output int                 pulses,
    output int                 reads,
    output int                 faults
);
    logic [7:0]    mem [2**AW];
    int            hits [2**AW];
    logic [7:0]    last = 8'h00;
    logic [AW-1:0] addr_p = '0;
    logic          drv_p = 1'b0;
    logic          started = 1'b0;
    int            wid = 0;
    wire           drv = !ce_b && !oe_b && !vpp_en;

    // Floating lines show the inverse of the last byte, so a stale sample never matches.
    assign dout = drv ? (id_hv ? (addr[0] ? DEV_ID : MAKER_ID) : mem[addr]) : ~last;

    // A pulse is judged when chip select returns high; a byte takes its data only
    // after as many pulses as this part needs, which lets the bench force retries.
    always @(posedge clk) begin
        if (new_part) begin
            foreach (mem[i]) begin
                mem[i] = 8'hFF;
                hits[i] = 0;
            end
            pulses = 0;
            reads = 0;
            faults = 0;
            wid = 0;
            started = 1'b0;
        end else begin
            if (drv) last = dout;
            if (drv && (!drv_p || addr != addr_p)) reads++;
            if (drv && din_oe) faults++;
            if (!ce_b && vpp_en) begin
                wid++;
            end else if (wid > 0) begin
                pulses++;
                if (wid != PW) faults++;
                if (!vcc_prog || !din_oe) faults++;
                if (!started && addr != 0) faults++;
                started = 1'b1;
                hits[addr]++;
                if (hits[addr] >= need) mem[addr] = mem[addr] & din;
                wid = 0;
            end
        end
        drv_p = drv;
        addr_p = addr;
    end
endmodule : opv_mem_model

// >>> tb/opv_prog_tb.sv
// Self-checking bench for the programmer against the behavioural memory model.
`timescale 1ns/1ps
module opv_prog_tb;
    import opv_pkg::*;
    localparam int         AW    = 4;
    localparam int         PW    = 8;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
    localparam logic [7:0] DEV   = 8'hC3; // Arbitrary value.
    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    logic          start = 1'b0;
    logic          id_req = 1'b0;
    logic          clk_en = 1'b1;
    logic          src_valid = 1'b0;
    logic [7:0]    src_data = 8'h00;
    logic          new_part = 1'b1;
    logic [3:0]    need = 4'h1;
    logic          src_ready, data_oe, ce_b, oe_b, vpp_en, vcc_prog, id_hv;
    logic          busy, done, pass, fail;
    logic [AW-1:0] addr;
    logic [7:0]    data_drv, data_out, id_mfr, id_dev;
    int            pulses, reads, faults;
    int            fails = 0;
    int            total_checks = 0;

    // The clock runs at 250 MHz.
    always #2 clk = ~clk;

    opv_prog #(.ADW(AW), .PROGRAM_PULSE_WIDTH(PW), .SETUP_CYCLES(2), .READ_CYCLES(6)) uut (
        .CLOCK(clk), .RST_B(rst_b), .CLK_EN(clk_en), .START(start), .ID_REQ(id_req),
        .SRC_DATA(src_data), .SRC_VALID(src_valid), .SRC_READY(src_ready),
        .PIN_ADDR(addr), .PIN_DATA_DRV(data_drv), .PIN_DATA_OE(data_oe),
        .DATA_OUT_LINES(data_out), .PIN_CE_B(ce_b), .PIN_OE_B(oe_b), .PIN_VPP_EN(vpp_en),
        .PIN_VCC_PROG(vcc_prog), .ID_HIGH_VOLTAGE_LINE(id_hv), .BUSY(busy), .DONE(done),
        .PASS(pass), .FAIL(fail), .ID_MFR(id_mfr), .ID_DEV(id_dev));

    opv_mem_model #(.AW(AW), .PW(PW), .MAKER_ID(MAKER), .DEV_ID(DEV)) model (
        .clk(clk), .new_part(new_part), .need(need), .addr(addr), .din(data_drv),
        .din_oe(data_oe), .ce_b(ce_b), .oe_b(oe_b), .vpp_en(vpp_en), .vcc_prog(vcc_prog),
        .id_hv(id_hv), .dout(data_out), .pulses(pulses), .reads(reads), .faults(faults));

    // Source image byte for a given position in the stream; never all ones, so a blank
    // byte can never verify by chance and every byte really needs its pulses.
    function automatic logic [7:0] img(input int i);
        return 8'hA6 ^ {i[3:0], i[3:0]};
    endfunction : img

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task automatic check1(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s is %b", $time, what, got);
        end
    endtask : check1

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s is %h not %h", $time, what, got, exp);
        end
    endtask : check8

    task automatic check_cnt(input int got, input int exp, input string what);
        total_checks++;
        if (got != exp) begin
            fails++;
            $display("[ERR] %0t %s is %0d not %0d", $time, what, got, exp);
        end
    endtask : check_cnt

    // Waits, under a bound, for the end pulse while streaming the image three times.
    task automatic serve(input int limit);
        int n;
        int idx;
        n = 0;
        idx = 0;
        while (done !== 1'b1 && n < limit) begin
            @(posedge clk);
            n++;
            if (src_valid && src_ready === 1'b1) begin
                idx++;
                src_data <= img(idx);
                if (idx == 3 * (2 ** AW)) src_valid <= 1'b0;
            end
        end
        if (n >= limit) begin
            fails++;
            $display("[ERR] %0t wait for done ran out", $time);
            summarize();
        end
    endtask : serve

    // Identification read of both bytes.
    task automatic run_id();
        id_req <= 1'b1;
        @(posedge clk);
        id_req <= 1'b0;
        clk_en <= 1'b0;
        repeat (4) @(posedge clk);
        check1(ce_b, 1'b1, "chip select while frozen");
        check1(busy, 1'b1, "busy while frozen");
        clk_en <= 1'b1;
        serve(1000);
        @(posedge clk);
        check8(id_mfr, MAKER, "maker byte");
        check8(id_dev, DEV, "type byte");
        $display("Test identification ended");
    endtask : run_id

    // One session on a fresh part whose bytes each need nv pulses.
    task automatic run_prog(input logic [3:0] nv, input logic ok, input int np, input int nr);
        new_part <= 1'b1;
        need <= nv;
        @(posedge clk);
        new_part <= 1'b0;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        src_valid <= 1'b1;
        src_data <= img(0);
        serve(40000);
        @(posedge clk);
        check1(pass, ok, "pass flag");
        check1(fail, !ok, "fail flag");
        check_cnt(pulses, np, "pulse count");
        check_cnt(reads, nr, "read count");
        check_cnt(faults, 0, "pin faults");
        check1(busy, 1'b0, "busy");
        $display("Test program with %0d pulses per byte ended", nv);
    endtask : run_prog

    // Reset, then identification, a clean part, a slow part and a dead part.
    initial begin
        repeat (6) @(posedge clk);
        check1(ce_b, 1'b1, "chip select in reset");
        check1(vpp_en, 1'b0, "vpp in reset");
        check1(src_ready, 1'b0, "ready in reset");
        rst_b <= 1'b1;
        new_part <= 1'b0;
        repeat (2) @(posedge clk);
        check1(src_ready, 1'b1, "ready after reset");
        run_id();
        run_prog(4'h1, 1'b1, 16, 32);
        run_prog(4'h3, 1'b1, 48, 64);
        run_prog(4'hC, 1'b0, 26, 11);
        summarize();
    end
endmodule : opv_prog_tb
